// File: lbc_pkg.sv
package lbc_pkg;

  // Bus cycle sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_STATUS = 4'h2,
    ST_CMD    = 4'h4,
    ST_DONE   = 4'h8
  } lbc_state_t;

  // Wait-state counts per target
  localparam logic [1:0] ROM_WAIT_LOW = 2'h2;
  localparam logic [1:0] ROM_WAIT_HIGH = 2'h3;
  localparam logic [1:0] RAM_WAIT_LOW = 2'h0;
  localparam logic [1:0] RAM_WAIT_HIGH = 2'h1;
  localparam logic [1:0] NO_WAIT = 2'h0;

  // Extra command cycles before the column strobe on slow RAM reads
  localparam logic [1:0] CAS_DELAY_SLOW = 2'h1;
  localparam logic [1:0] CAS_DELAY_FAST = 2'h0;

  // Crystal divider: toggle every half period of the divided clock
  localparam int XTAL_DIVISOR = 12;
  localparam int XTAL_HALF = XTAL_DIVISOR / 2;
  localparam int XTAL_CNT_W = 3;

  // Processor reset pulse length
  localparam int CLK_PERIOD_NS = 4;
  localparam int RESET_HOLD_NS = 1000;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CNT_W = 9;

  // Attributes of one bus cycle, captured at its start
  typedef struct packed {
    logic isWrite;
    logic isRead;
    logic isHalt;
    logic isShutdown;
    logic isRom;
    logic isOnboard;
    logic isCoproc;
    logic needSplit;
    logic lowByte;
    logic highByte;
    logic [1:0] waits;
    logic [1:0] casDelay;
  } lbc_cycle_t;

  // A two-way pin as driven: level and its output enable
  typedef struct packed {
    logic out;
    logic oe;
  } lbc_pin_drive_t;

endpackage

// File: lbc_clock_divider.sv
`timescale 1ns/1ns
// Counts rising edges of a slow input and toggles every HALF edges
module lbc_clock_divider
  import lbc_pkg::*;
#(
  parameter int CNT_W = 3,
  parameter int HALF = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Edge in, divided level out
  input wire logic edgeTick,
  output logic divOut
);

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic div_r;
  logic div_nxt;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF - 1);

  // Count edges, flip the output at each half period
  always_comb begin
    count_nxt = count_r;
    div_nxt = div_r;
    if (edgeTick) begin
      if (count_r == LAST) begin
        count_nxt = '0;
        div_nxt = ~div_r;
      end else begin
        count_nxt = count_r + CNT_W'(1);
      end
    end
  end

  // Registers only
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
      div_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      div_r <= div_nxt;
    end
  end

  assign divOut = div_r;

endmodule

// File: lbc_pulse_stretch.sv
`timescale 1ns/1ns
// Holds its output while a level is active, then for LENGTH more cycles
module lbc_pulse_stretch
  import lbc_pkg::*;
#(
  parameter int CNT_W = 9,
  parameter int LENGTH = 250
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Trigger and stretched output
  input wire logic trigger,
  output logic pulseOut
);

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic out_r;
  logic out_nxt;
  localparam logic [CNT_W-1:0] LOAD = CNT_W'(LENGTH - 1);

  // Reload on trigger; a held trigger keeps the pulse going
  always_comb begin
    count_nxt = count_r;
    out_nxt = out_r;
    if (trigger) begin
      count_nxt = LOAD;
      out_nxt = 1'b1;
    end else if (count_r != '0) begin
      count_nxt = count_r - CNT_W'(1);
    end else begin
      out_nxt = 1'b0;
    end
  end

  // Starts asserted so the processor comes up in reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= LOAD;
      out_r <= 1'b1;
    end else begin
      count_r <= count_nxt;
      out_r <= out_nxt;
    end
  end

  assign pulseOut = out_r;

endmodule

// File: lbc_local_bus_ctrl.sv
`timescale 1ns/1ns
// Behaviour
// - ROM waits: two when low, three high
// - RAM reads: one wait high, zero low
// - Crystal clock out buffers the oscillator
// - Divided clock is crystal divided by twelve
// - High byte enable gates transceiver, decides splitting
// - DMA drives high byte enable from DMA enables
// - Low-active enables for high and low transceivers
// - Direction high write or idle, low read
// - Direction changes only with both enables off
// - Address strobe each cycle except halt cycles
// - Memory latch strobe low after status phase
// - DMA active low while either DMA enable low
// - CPU reset from supply, soft reset, shutdown
// - Peripheral memory commands driven only outside DMA
// - Soft reset acts on rising edge only
// - Shutdown: addr1 low, memory, both status low
module lbc_local_bus_ctrl
  import lbc_pkg::*;
#(
  parameter int RESET_HOLD = RESET_HOLD_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Processor status and address
  input wire logic cycle_status_0_n,
  input wire logic cycle_status_1_n,
  input wire logic mem_io_select,
  input wire logic cpu_addr_bit0,
  input wire logic cpu_addr_bit1,
  // Target decode and wait selects
  input wire logic rom_select_n,
  input wire logic onboard_mem,
  input wire logic coproc_addr_hit,
  input wire logic rom_wait_select,
  input wire logic ram_read_wait_select,
  // Reset sources
  input wire logic supply_good_in,
  input wire logic soft_reset_request,
  // Crystal oscillator and its clocks
  input wire logic xtal_osc_in,
  output logic crystal_clock_out,
  output logic div12_clock_out,
  // DMA
  input wire logic dma_enable_one_n,
  input wire logic dma_enable_two_n,
  input wire logic system_addr_bit0,
  output logic dma_cycle_active_n,
  // High byte enable, two-way
  input wire logic peripheral_high_byte_enable_n_in,
  output logic peripheral_high_byte_enable_n_out,
  output logic peripheral_high_byte_enable_n_oe,
  // Peripheral memory commands, two-way
  input wire logic periph_mem_write_n_in,
  output logic periph_mem_write_n_out,
  output logic periph_mem_write_n_oe,
  input wire logic periph_mem_read_n_in,
  output logic periph_mem_read_n_out,
  output logic periph_mem_read_n_oe,
  // Transceivers and latches
  output logic high_byte_xcvr_enable_n,
  output logic low_byte_xcvr_enable_n,
  output logic transfer_direction,
  output logic addr_latch_strobe,
  output logic memory_address_latch_strobe,
  output logic byte_split_active,
  // DRAM strobes
  output logic row_strobe_n,
  output logic col_strobe_n,
  // Resets and coprocessor
  output logic cpu_reset_out,
  output logic coproc_select_n,
  output logic coproc_reset,
  // Peripheral commands seen during DMA
  output logic dma_mem_write_seen,
  output logic dma_mem_read_seen
);

  lbc_state_t state_r, state_nxt;
  lbc_cycle_t cyc_r, cyc_nxt, cycNew;
  logic [1:0] waitCnt_r, waitCnt_nxt;
  logic [1:0] cmdCnt_r, cmdCnt_nxt;
  logic splitPhase_r, splitPhase_nxt;
  logic hiEn_r, hiEn_nxt;
  logic loEn_r, loEn_nxt;
  logic dir_r, dir_nxt;
  logic ale_r, ale_nxt;
  logic memLatch_r, memLatch_nxt;
  logic ras_r, ras_nxt;
  logic cas_r, cas_nxt;
  logic coproc_select_r, coproc_select_nxt;
  logic osc_r, oscPrev_r;
  logic softPrev_r;
  logic dmaAct_r, dmaAct_nxt;
  lbc_pin_drive_t bhe_r, bhe_nxt;
  lbc_pin_drive_t memW_r, memW_nxt;
  lbc_pin_drive_t memR_r, memR_nxt;
  logic dmaWrSeen_r, dmaRdSeen_r;
  logic cycleStart, shutdownHit, softEdge, resetTrigger, bheLive, oscRise;

  // Oscillator sampled once; rising edges feed the divider
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      osc_r <= 1'b0;
      oscPrev_r <= 1'b0;
      softPrev_r <= 1'b0;
    end else begin
      osc_r <= xtal_osc_in;
      oscPrev_r <= osc_r;
      softPrev_r <= soft_reset_request;
    end
  end

  assign oscRise = osc_r & ~oscPrev_r;
  assign crystal_clock_out = osc_r;

  lbc_clock_divider #(
    .CNT_W(XTAL_CNT_W),
    .HALF(XTAL_HALF)
  ) u_div12 (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .edgeTick(oscRise),
    .divOut(div12_clock_out)
  );

  // Reset sources: missing supply, soft reset edge, shutdown status
  assign softEdge = soft_reset_request & ~softPrev_r;
  assign shutdownHit = cycleStart & cycNew.isShutdown;
  assign resetTrigger = ~supply_good_in | softEdge | shutdownHit;

  lbc_pulse_stretch #(
    .CNT_W(RESET_CNT_W),
    .LENGTH(RESET_HOLD)
  ) u_cpu_reset (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .trigger(resetTrigger),
    .pulseOut(cpu_reset_out)
  );

  // Coprocessor follows the system reset only; a shutdown restarts the CPU alone
  lbc_pulse_stretch #(
    .CNT_W(RESET_CNT_W),
    .LENGTH(RESET_HOLD)
  ) u_coproc_reset (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .trigger(~supply_good_in),
    .pulseOut(coproc_reset)
  );

  // High byte enable as seen internally: ours during DMA, else the pin
  assign bheLive = bhe_r.oe ? bhe_r.out : peripheral_high_byte_enable_n_in;

  // Decode of a new cycle from status lines
  assign cycleStart = (state_r == ST_IDLE) & ~(cycle_status_0_n & cycle_status_1_n);
  always_comb begin
    cycNew = '0;
    cycNew.isWrite = ~cycle_status_0_n & cycle_status_1_n;
    cycNew.isRead = cycle_status_0_n & ~cycle_status_1_n;
    cycNew.isHalt = ~cycle_status_0_n & ~cycle_status_1_n & mem_io_select;
    cycNew.isShutdown = cycNew.isHalt & ~cpu_addr_bit1;
    cycNew.isRom = mem_io_select & ~rom_select_n;
    cycNew.isOnboard = mem_io_select & onboard_mem & rom_select_n;
    cycNew.isCoproc = ~mem_io_select & coproc_addr_hit;
    cycNew.lowByte = ~cpu_addr_bit0;
    cycNew.highByte = ~bheLive;
    // Off-board word access to an even address runs as two byte transfers
    cycNew.needSplit = ~bheLive & ~cpu_addr_bit0 & ~onboard_mem & ~cycNew.isHalt;
    if (cycNew.isRom) begin
      cycNew.waits = rom_wait_select ? ROM_WAIT_HIGH : ROM_WAIT_LOW;
    end else if (cycNew.isOnboard && cycNew.isRead) begin
      cycNew.waits = ram_read_wait_select ? RAM_WAIT_HIGH : RAM_WAIT_LOW;
    end else begin
      cycNew.waits = NO_WAIT;
    end
    cycNew.casDelay = (cycNew.isRead && ram_read_wait_select) ?
                      CAS_DELAY_SLOW : CAS_DELAY_FAST;
  end

  // Cycle sequencer and the strobes that follow it
  always_comb begin
    state_nxt = state_r;
    cyc_nxt = cyc_r;
    waitCnt_nxt = waitCnt_r;
    cmdCnt_nxt = cmdCnt_r;
    splitPhase_nxt = splitPhase_r;
    case (state_r)
      ST_IDLE: begin
        if (cycleStart) begin
          cyc_nxt = cycNew;
          state_nxt = ST_STATUS;
        end
      end
      ST_STATUS: begin
        waitCnt_nxt = cyc_r.waits;
        cmdCnt_nxt = 2'h0;
        splitPhase_nxt = 1'b0;
        state_nxt = cyc_r.isHalt ? ST_DONE : ST_CMD;
      end
      ST_CMD: begin
        if (cmdCnt_r != 2'h3) begin
          cmdCnt_nxt = cmdCnt_r + 2'h1;
        end
        if (waitCnt_r != 2'h0) begin
          waitCnt_nxt = waitCnt_r - 2'h1;
        end else if (cyc_r.needSplit && !splitPhase_r) begin
          splitPhase_nxt = 1'b1;
          waitCnt_nxt = cyc_r.waits;
        end else begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        // Wait for the processor to drop its status before idling
        if (cycle_status_0_n && cycle_status_1_n) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Output strobes derived from the next state so they are registered
  always_comb begin
    hiEn_nxt = 1'b0;
    loEn_nxt = 1'b0;
    dir_nxt = dir_r;
    ale_nxt = (state_nxt == ST_STATUS) & ~cyc_nxt.isHalt;
    memLatch_nxt = (state_nxt != ST_CMD);
    ras_nxt = (state_nxt == ST_CMD) & cyc_nxt.isOnboard;
    cas_nxt = ras_nxt & (cmdCnt_nxt >= cyc_nxt.casDelay);
    coproc_select_nxt = (state_nxt == ST_CMD) & cyc_nxt.isCoproc;
    if (state_nxt == ST_CMD && !cyc_nxt.isCoproc) begin
      if (cyc_nxt.needSplit) begin
        loEn_nxt = ~splitPhase_nxt;
        hiEn_nxt = splitPhase_nxt & cyc_nxt.highByte;
      end else begin
        loEn_nxt = cyc_nxt.lowByte;
        hiEn_nxt = cyc_nxt.highByte;
      end
    end
    // Direction moves only on entry to status or idle, when enables are off
    if (state_nxt == ST_STATUS && state_r == ST_IDLE) begin
      dir_nxt = ~cyc_nxt.isRead;
    end else if (state_nxt == ST_IDLE) begin
      dir_nxt = 1'b1;
    end
  end

  // DMA ownership and the two-way pins
  always_comb begin
    dmaAct_nxt = ~(dma_enable_one_n & dma_enable_two_n);
    bhe_nxt.oe = dmaAct_nxt;
    if (!dma_enable_two_n) begin
      bhe_nxt.out = 1'b0;
    end else if (!dma_enable_one_n) begin
      bhe_nxt.out = ~system_addr_bit0;
    end else begin
      bhe_nxt.out = 1'b1;
    end
    // Commands go out only while the processor owns the bus
    memW_nxt.oe = ~dmaAct_nxt;
    memR_nxt.oe = ~dmaAct_nxt;
    memW_nxt.out = ~((state_nxt == ST_CMD) & cyc_nxt.isWrite & mem_io_select);
    memR_nxt.out = ~((state_nxt == ST_CMD) & cyc_nxt.isRead & mem_io_select);
  end

  // All state of the sequencer and of the pins other than the clock and reset outputs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      cyc_r <= '0;
      waitCnt_r <= 2'h0;
      cmdCnt_r <= 2'h0;
      splitPhase_r <= 1'b0;
      hiEn_r <= 1'b0;
      loEn_r <= 1'b0;
      dir_r <= 1'b1;
      ale_r <= 1'b0;
      memLatch_r <= 1'b1;
      ras_r <= 1'b0;
      cas_r <= 1'b0;
      coproc_select_r <= 1'b0;
      dmaAct_r <= 1'b0;
      bhe_r <= '{out: 1'b1, oe: 1'b0};
      memW_r <= '{out: 1'b1, oe: 1'b1};
      memR_r <= '{out: 1'b1, oe: 1'b1};
      dmaWrSeen_r <= 1'b0;
      dmaRdSeen_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cyc_r <= cyc_nxt;
      waitCnt_r <= waitCnt_nxt;
      cmdCnt_r <= cmdCnt_nxt;
      splitPhase_r <= splitPhase_nxt;
      hiEn_r <= hiEn_nxt;
      loEn_r <= loEn_nxt;
      dir_r <= dir_nxt;
      ale_r <= ale_nxt;
      memLatch_r <= memLatch_nxt;
      ras_r <= ras_nxt;
      cas_r <= cas_nxt;
      coproc_select_r <= coproc_select_nxt;
      dmaAct_r <= dmaAct_nxt;
      bhe_r <= bhe_nxt;
      memW_r <= memW_nxt;
      memR_r <= memR_nxt;
      // Pin levels are read only while the pins are inputs
      dmaWrSeen_r <= dmaAct_r & ~periph_mem_write_n_in;
      dmaRdSeen_r <= dmaAct_r & ~periph_mem_read_n_in;
    end
  end

  // Pin assignments, active-low where named so
  assign high_byte_xcvr_enable_n = ~hiEn_r;
  assign low_byte_xcvr_enable_n = ~loEn_r;
  assign transfer_direction = dir_r;
  assign addr_latch_strobe = ale_r;
  assign memory_address_latch_strobe = memLatch_r;
  assign byte_split_active = splitPhase_r;
  assign row_strobe_n = ~ras_r;
  assign col_strobe_n = ~cas_r;
  assign coproc_select_n = ~coproc_select_r;
  assign dma_cycle_active_n = ~dmaAct_r;
  assign peripheral_high_byte_enable_n_out = bhe_r.out;
  assign peripheral_high_byte_enable_n_oe = bhe_r.oe;
  assign periph_mem_write_n_out = memW_r.out;
  assign periph_mem_write_n_oe = memW_r.oe;
  assign periph_mem_read_n_out = memR_r.out;
  assign periph_mem_read_n_oe = memR_r.oe;
  assign dma_mem_write_seen = dmaWrSeen_r;
  assign dma_mem_read_seen = dmaRdSeen_r;

endmodule

// File: lbc_periph_side.sv
`timescale 1ns/1ns
// Far side of the two-way pins: pulled-up wires plus a DMA master that
// drives only what the controller has released
module lbc_periph_side (
  // Controller side of the pins
  input wire logic bheOut,
  input wire logic bheOe,
  input wire logic wrOut,
  input wire logic wrOe,
  input wire logic rdOut,
  input wire logic rdOe,
  // Far-side requests
  input wire logic bheDrive,
  input wire logic bheLevel,
  input wire logic wrPull,
  input wire logic rdPull,
  // Resolved wire levels
  output logic bheWire,
  output logic wrWire,
  output logic rdWire
);
  // Commands pulled low by the far side only once the controller lets go
  assign wrWire = wrOe ? wrOut : ~wrPull;
  assign rdWire = rdOe ? rdOut : ~rdPull;
  // Byte enable comes from the far side outside DMA; idle level is the pull-up
  assign bheWire = bheOe ? bheOut : (bheDrive ? bheLevel : 1'b1);
endmodule

// File: lbc_checker.sv
`timescale 1ns/1ns
// Port-level checks on the local bus cycle controller
module lbc_checker #(
  parameter int RESET_HOLD = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Inputs watched
  input wire logic cycle_status_0_n,
  input wire logic cycle_status_1_n,
  input wire logic xtal_osc_in,
  input wire logic soft_reset_request,
  input wire logic supply_good_in,
  input wire logic dma_enable_one_n,
  input wire logic dma_enable_two_n,
  input wire logic system_addr_bit0,
  // Outputs watched
  input wire logic crystal_clock_out,
  input wire logic dma_cycle_active_n,
  input wire logic peripheral_high_byte_enable_n_out,
  input wire logic peripheral_high_byte_enable_n_oe,
  input wire logic periph_mem_write_n_oe,
  input wire logic periph_mem_read_n_oe,
  input wire logic high_byte_xcvr_enable_n,
  input wire logic low_byte_xcvr_enable_n,
  input wire logic transfer_direction,
  input wire logic addr_latch_strobe,
  input wire logic memory_address_latch_strobe,
  input wire logic cpu_reset_out,
  input wire logic coproc_reset
);
  logic [9:0] highRun_r, highRun_nxt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Length of the running reset pulse, so a short pulse is caught
  always_comb begin
    highRun_nxt = cpu_reset_out ? highRun_r + 10'h1 : 10'h0;
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      highRun_r <= 10'h0;
    end else begin
      highRun_r <= highRun_nxt;
    end
  end
  xtal_copy_a: assert property (crystal_clock_out == $past(xtal_osc_in))
    else $error("oscillator copy wrong");
  dir_quiet_a: assert property ($changed(transfer_direction) |->
    high_byte_xcvr_enable_n && low_byte_xcvr_enable_n
    && $past(high_byte_xcvr_enable_n && low_byte_xcvr_enable_n))
    else $error("direction moved with a transceiver on");
  dir_read_a: assert property (!transfer_direction |->
    $past(cycle_status_0_n) && !$past(cycle_status_1_n))
    else $error("direction low outside a read");
  dma_flag_a: assert property (dma_cycle_active_n ==
    ($past(dma_enable_one_n) && $past(dma_enable_two_n)))
    else $error("dma flag wrong");
  bhe_dma_a: assert property (!dma_cycle_active_n |-> peripheral_high_byte_enable_n_oe
    && peripheral_high_byte_enable_n_out ==
    ($past(dma_enable_two_n) ? ~$past(system_addr_bit0) : 1'b0))
    else $error("byte enable wrong in dma");
  cmd_oe_a: assert property (periph_mem_read_n_oe == dma_cycle_active_n
    && periph_mem_write_n_oe == dma_cycle_active_n)
    else $error("command pin direction wrong");
  ale_halt_a: assert property (addr_latch_strobe |->
    $past(cycle_status_0_n) || $past(cycle_status_1_n))
    else $error("strobe on a halt cycle");
  latch_fall_a: assert property ($rose(addr_latch_strobe) |=>
    !addr_latch_strobe && !memory_address_latch_strobe)
    else $error("memory latch not low after status");
  latch_rise_a: assert property ($rose(memory_address_latch_strobe) |->
    high_byte_xcvr_enable_n && low_byte_xcvr_enable_n)
    else $error("memory latch rose mid transfer");
  soft_edge_a: assert property ($rose(soft_reset_request) |-> ##[1:3] cpu_reset_out)
    else $error("soft reset edge ignored");
  supply_a: assert property (!supply_good_in |-> ##[1:2] (cpu_reset_out && coproc_reset))
    else $error("supply fail gave no reset");
  hold_len_a: assert property ($fell(cpu_reset_out) |-> highRun_r >= RESET_HOLD)
    else $error("reset pulse too short");
  ale_c: cover property ($rose(addr_latch_strobe));
  dma_c: cover property ($fell(dma_cycle_active_n));
  rst_c: cover property ($rose(cpu_reset_out));
endmodule
bind lbc_local_bus_ctrl lbc_checker #(.RESET_HOLD(RESET_HOLD)) chk_u (.*);

// File: local_bus_cycle_control_bench.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
      bad_count++; \
      $display("MISMATCH %s exp %0h got %0h", nm, ex, got); \
    end \
  end
module local_bus_cycle_control_bench;
  logic clk_sys, reset_n;
  logic cycle_status_0_n, cycle_status_1_n, mem_io_select, cpu_addr_bit0, cpu_addr_bit1;
  logic rom_select_n, onboard_mem, coproc_addr_hit, rom_wait_select, ram_read_wait_select;
  logic supply_good_in, soft_reset_request, xtal_osc_in, crystal_clock_out, div12_clock_out;
  logic dma_enable_one_n, dma_enable_two_n, system_addr_bit0, dma_cycle_active_n;
  logic peripheral_high_byte_enable_n_in, peripheral_high_byte_enable_n_out;
  logic peripheral_high_byte_enable_n_oe;
  logic periph_mem_write_n_in, periph_mem_write_n_out, periph_mem_write_n_oe;
  logic periph_mem_read_n_in, periph_mem_read_n_out, periph_mem_read_n_oe;
  logic high_byte_xcvr_enable_n, low_byte_xcvr_enable_n, transfer_direction;
  logic addr_latch_strobe, memory_address_latch_strobe, byte_split_active;
  logic row_strobe_n, col_strobe_n, cpu_reset_out, coproc_select_n, coproc_reset;
  logic dma_mem_write_seen, dma_mem_read_seen;
  logic bheDrive, bheLevel, wrPull, rdPull;
  int bad_count, cmp_count, cycles;

  // Short reset hold keeps the run brief
  lbc_local_bus_ctrl #(.RESET_HOLD(4)) dut_u (.*);
  lbc_periph_side far_u (
    .bheOut(peripheral_high_byte_enable_n_out), .bheOe(peripheral_high_byte_enable_n_oe),
    .wrOut(periph_mem_write_n_out), .wrOe(periph_mem_write_n_oe),
    .rdOut(periph_mem_read_n_out), .rdOe(periph_mem_read_n_oe),
    .bheDrive(bheDrive), .bheLevel(bheLevel), .wrPull(wrPull), .rdPull(rdPull),
    .bheWire(peripheral_high_byte_enable_n_in), .wrWire(periph_mem_write_n_in),
    .rdWire(periph_mem_read_n_in)
  );

  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // A hung cycle must not stall the run
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      print_verdict();
    end
  end

  // One bus cycle; cfg = s0,s1,mio,a0,a1,rom,onboard,coproc,romWait,ramWait
  task automatic runCycle(input string nm, input logic [9:0] cfg, input logic bhe,
      input int eLen, eLo, eHi, eCol, eCop, eAle, input logic eDir, eRst);
    int len, lo, hi, col, cop, ale, ml, rst, sp, cmd;
    logic dirAll;
    {len, lo, hi, col, cop, ale, ml, rst, sp, cmd} = '0;
    dirAll = 1'b1;
    @(negedge clk_sys);
    bheLevel = bhe;
    {cycle_status_0_n, cycle_status_1_n, mem_io_select, cpu_addr_bit0, cpu_addr_bit1,
      rom_select_n, onboard_mem, coproc_addr_hit, rom_wait_select, ram_read_wait_select} = cfg;
    @(negedge clk_sys);
    // Wait selects move after the cycle is taken; the count must not
    rom_wait_select = ~rom_wait_select;
    ram_read_wait_select = ~ram_read_wait_select;
    repeat (12) begin
      len += (low_byte_xcvr_enable_n === 1'b0 || high_byte_xcvr_enable_n === 1'b0);
      lo += (low_byte_xcvr_enable_n === 1'b0);
      hi += (high_byte_xcvr_enable_n === 1'b0);
      col += (row_strobe_n === 1'b0 && col_strobe_n === 1'b1);
      cop += (coproc_select_n === 1'b0);
      ale += (addr_latch_strobe === 1'b1);
      ml += (memory_address_latch_strobe === 1'b0);
      rst += (cpu_reset_out === 1'b1);
      sp += (high_byte_xcvr_enable_n === 1'b0 && byte_split_active === 1'b1);
      cmd += (periph_mem_read_n_out === 1'b0 || periph_mem_write_n_out === 1'b0);
      dirAll &= transfer_direction;
      @(negedge clk_sys);
    end
    cycle_status_0_n = 1'b1;
    cycle_status_1_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    `CHK({nm, " len"}, eLen, len)
    `CHK({nm, " lo"}, eLo, lo)
    `CHK({nm, " hi"}, eHi, hi)
    `CHK({nm, " col"}, eCol, col)
    `CHK({nm, " cop"}, eCop, cop)
    `CHK({nm, " ale"}, eAle, ale)
    `CHK({nm, " latch"}, eLen + eCop, ml)
    `CHK({nm, " split hi"}, eLen - eLo, sp)
    `CHK({nm, " cmd"}, eLen, cmd)
    `CHK({nm, " dir"}, eDir, dirAll)
    `CHK({nm, " rst"}, eRst, rst > 0)
    `CHK({nm, " idle dir"}, 1'b1, transfer_direction)
    `CHK({nm, " idle latch"}, 1'b1, memory_address_latch_strobe)
    $display("test %s done", nm);
  endtask

  // Oscillator copy and divide by twelve
  task automatic clockTest();
    int tog;
    logic last;
    tog = 0;
    last = div12_clock_out;
    repeat (48) begin
      repeat (3) @(negedge clk_sys);
      `CHK("osc copy", xtal_osc_in, crystal_clock_out)
      xtal_osc_in = ~xtal_osc_in;
      tog += (div12_clock_out !== last);
      last = div12_clock_out;
    end
    repeat (6) @(negedge clk_sys);
    tog += (div12_clock_out !== last);
    `CHK("div12 toggles", 4, tog)
    $display("test clock done");
  endtask

  // Each DMA enable, then release; far side pulls a command meanwhile
  task automatic dmaTest();
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_sys);
      dma_enable_two_n = (i != 0);
      dma_enable_one_n = (i == 0);
      system_addr_bit0 = (i == 1);
      wrPull = (i == 0);
      rdPull = (i != 0);
      repeat (3) @(negedge clk_sys);
      `CHK("dma active", 1'b0, dma_cycle_active_n)
      `CHK("bhe oe", 1'b1, peripheral_high_byte_enable_n_oe)
      `CHK("bhe out", i == 2, peripheral_high_byte_enable_n_out)
      `CHK("cmd oe", 1'b0, periph_mem_read_n_oe)
      `CHK("wr seen", i == 0, dma_mem_write_seen)
      `CHK("rd seen", i != 0, dma_mem_read_seen)
      dma_enable_one_n = 1'b1;
      dma_enable_two_n = 1'b1;
      wrPull = 1'b0;
      rdPull = 1'b0;
      repeat (3) @(negedge clk_sys);
      `CHK("dma idle", 1'b1, dma_cycle_active_n)
      `CHK("cmd drive", 1'b1, periph_mem_write_n_oe)
    end
    $display("test dma done");
  endtask

  // Soft reset edge versus level, then supply failure
  task automatic resetTest();
    @(negedge clk_sys);
    soft_reset_request = 1'b1;
    repeat (3) @(negedge clk_sys);
    `CHK("soft reset", 1'b1, cpu_reset_out)
    `CHK("coproc quiet", 1'b0, coproc_reset)
    repeat (12) @(negedge clk_sys);
    `CHK("level ignored", 1'b0, cpu_reset_out)
    soft_reset_request = 1'b0;
    supply_good_in = 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK("supply reset", 1'b1, cpu_reset_out)
    `CHK("coproc reset", 1'b1, coproc_reset)
    supply_good_in = 1'b1;
    repeat (12) @(negedge clk_sys);
    `CHK("supply back", 1'b0, cpu_reset_out)
    $display("test reset done");
  endtask

  // Main sequence
  initial begin
    {cycle_status_0_n, cycle_status_1_n, mem_io_select, cpu_addr_bit1} = 4'hf;
    {cpu_addr_bit0, rom_select_n, onboard_mem, coproc_addr_hit} = 4'h4;
    {rom_wait_select, ram_read_wait_select, soft_reset_request, xtal_osc_in} = 4'h0;
    {supply_good_in, dma_enable_one_n, dma_enable_two_n, system_addr_bit0} = 4'he;
    {bheDrive, bheLevel, wrPull, rdPull} = 4'h8;
    reset_n = 1'b0;
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (10) @(negedge clk_sys);
    runCycle("rom2", 10'h2a0, 1'b1, 3, 3, 0, 0, 0, 1, 1'b0, 1'b0);
    runCycle("rom3", 10'h2a2, 1'b1, 4, 4, 0, 0, 0, 1, 1'b0, 1'b0);
    runCycle("ramslow", 10'h2b9, 1'b0, 2, 2, 2, 1, 0, 1, 1'b0, 1'b0);
    runCycle("ramfast", 10'h2b8, 1'b0, 1, 1, 1, 0, 0, 1, 1'b0, 1'b0);
    runCycle("ramwr", 10'h1b9, 1'b0, 1, 1, 1, 0, 0, 1, 1'b1, 1'b0);
    runCycle("split", 10'h1b0, 1'b0, 2, 1, 1, 0, 0, 1, 1'b1, 1'b0);
    runCycle("byte", 10'h1b0, 1'b1, 1, 1, 0, 0, 0, 1, 1'b1, 1'b0);
    runCycle("coproc", 10'h134, 1'b1, 0, 0, 0, 0, 1, 1, 1'b1, 1'b0);
    runCycle("halt", 10'h0b0, 1'b1, 0, 0, 0, 0, 0, 0, 1'b1, 1'b0);
    runCycle("shutdown", 10'h090, 1'b1, 0, 0, 0, 0, 0, 0, 1'b1, 1'b1);
    clockTest();
    dmaTest();
    resetTest();
    print_verdict();
  end
endmodule
